//--- common/sdc_pkg.sv
// package for the sdram command decoder
package sdc_pkg;
   localparam int ROW_W = 14;
   localparam int COL_W = 10;
   localparam int AP_BIT = 10;
   localparam int BA_W = 3;
   localparam int BA_W_SMALL = 2;
   localparam int DENSITY_1GB_MBIT = 1024;
   localparam int DENSITY_DEFAULT_MBIT = 256;
   localparam logic [BA_W-1:0] BA_RESET = 3'h0;
   localparam logic [ROW_W-1:0] ADDR_RESET = 14'h0000;

   typedef enum logic [13:0] {
      SDC_NONE      = 14'h0001,
      SDC_DESELECT  = 14'h0002,
      SDC_NOP       = 14'h0004,
      SDC_MODE_LOAD = 14'h0008,
      SDC_REFRESH   = 14'h0010,
      SDC_SR_ENTRY  = 14'h0020,
      SDC_SR_EXIT   = 14'h0040,
      SDC_PRE_BANK  = 14'h0080,
      SDC_PRE_ALL   = 14'h0100,
      SDC_ACTIVATE  = 14'h0200,
      SDC_READ      = 14'h0400,
      SDC_WRITE     = 14'h0800,
      SDC_PD_ENTRY  = 14'h1000,
      SDC_PD_EXIT   = 14'h2000
   } sdc_cmd_t;

   typedef enum logic [2:0] {
      SDC_ST_ACTIVE = 3'h1,
      SDC_ST_PDOWN  = 3'h2,
      SDC_ST_SREF   = 3'h4
   } sdc_pwr_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdc_pins_t;

   typedef struct packed {
      sdc_cmd_t cmd;
      logic [BA_W-1:0] bank;
      logic [ROW_W-1:0] addr;
      logic auto_pre;
      logic illegal;
   } sdc_dec_t;
endpackage : sdc_pkg

//--- hw/sdc_decoder.sv
// command decode stage of a ddr sdram with four banks, or eight when DENSITY_MBIT is 1024 or more
`timescale 1ns/1ns
module sdc_decoder #(
   parameter int DENSITY_MBIT = sdc_pkg::DENSITY_DEFAULT_MBIT,
   parameter int COL_BITS = sdc_pkg::COL_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // command pins
   input wire logic cke,
   input wire sdc_pkg::sdc_pins_t pins,
   input wire logic [sdc_pkg::BA_W-1:0] bank_addr,
   input wire logic [sdc_pkg::ROW_W-1:0] addr,
   input wire logic odt_req,
   // decoded command
   output sdc_pkg::sdc_dec_t dec,
   output logic refresh_run,
   output logic odt_en,
   output sdc_pkg::sdc_pwr_t pwr_state
);
   import sdc_pkg::*;

   initial begin
      if (COL_BITS < 1 || COL_BITS > AP_BIT || DENSITY_MBIT < 1) begin
         $error("sdc_decoder: unsupported parameters");
      end
   end

   localparam logic [BA_W-1:0] BA_MASK = (DENSITY_MBIT >= DENSITY_1GB_MBIT) ? 3'h7 : 3'h3;
   localparam logic [ROW_W-1:0] COL_MASK = ROW_W'((1 << COL_BITS) - 1);

   logic cke_prev_r;
   sdc_dec_t dec_r;
   sdc_dec_t dec_nxt;
   sdc_pwr_t pwr_r;
   sdc_pwr_t pwr_nxt;
   logic odt_r;
   logic refresh_r;
   logic idle_code;
   logic [BA_W-1:0] ba_used;

   // previous enable level
   always_ff @(posedge clock) begin
      if (rst) begin
         cke_prev_r <= 1'b0;
      end else begin
         cke_prev_r <= cke;
      end
   end

   assign idle_code = pins.cs_n || (pins.ras_n && pins.cas_n && pins.we_n);
   assign ba_used = bank_addr & BA_MASK;

   // command classification; odt_req deliberately not read
   always_comb begin
      dec_nxt.cmd = SDC_NONE;
      dec_nxt.bank = BA_RESET;
      dec_nxt.addr = ADDR_RESET;
      dec_nxt.auto_pre = 1'b0;
      dec_nxt.illegal = 1'b0;
      pwr_nxt = pwr_r;
      if (cke_prev_r && !cke) begin
         if (!pins.cs_n && !pins.ras_n && !pins.cas_n && pins.we_n && pwr_r == SDC_ST_ACTIVE) begin
            dec_nxt.cmd = SDC_SR_ENTRY;
            pwr_nxt = SDC_ST_SREF;
         end else if (idle_code && pwr_r == SDC_ST_ACTIVE) begin
            dec_nxt.cmd = SDC_PD_ENTRY;
            pwr_nxt = SDC_ST_PDOWN;
         end else begin
            dec_nxt.illegal = 1'b1;
         end
      end else if (!cke_prev_r && cke) begin
         if (idle_code && pwr_r == SDC_ST_SREF) begin
            dec_nxt.cmd = SDC_SR_EXIT;
            pwr_nxt = SDC_ST_ACTIVE;
         end else if (idle_code && pwr_r == SDC_ST_PDOWN) begin
            dec_nxt.cmd = SDC_PD_EXIT;
            pwr_nxt = SDC_ST_ACTIVE;
         end else if (idle_code) begin
            dec_nxt.cmd = SDC_NOP;
         end else begin
            dec_nxt.illegal = 1'b1;
         end
      end else if (!cke_prev_r) begin
         dec_nxt.cmd = SDC_NONE; // enable held low, power state kept as it was
      end else if (pins.cs_n) begin
         dec_nxt.cmd = SDC_DESELECT;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'h0: begin
               dec_nxt.cmd = SDC_MODE_LOAD;
               dec_nxt.bank = ba_used;
               dec_nxt.addr = addr;
            end
            3'h1: dec_nxt.cmd = SDC_REFRESH;
            3'h2: begin
               if (addr[AP_BIT]) begin
                  dec_nxt.cmd = SDC_PRE_ALL;
               end else begin
                  dec_nxt.cmd = SDC_PRE_BANK;
                  dec_nxt.bank = ba_used;
               end
            end
            3'h3: begin
               dec_nxt.cmd = SDC_ACTIVATE;
               dec_nxt.bank = ba_used;
               dec_nxt.addr = addr;
            end
            3'h4: begin
               dec_nxt.cmd = SDC_WRITE;
               dec_nxt.bank = ba_used;
               dec_nxt.addr = addr & COL_MASK;
               dec_nxt.auto_pre = addr[AP_BIT];
            end
            3'h5: begin
               dec_nxt.cmd = SDC_READ;
               dec_nxt.bank = ba_used;
               dec_nxt.addr = addr & COL_MASK;
               dec_nxt.auto_pre = addr[AP_BIT];
            end
            3'h7: dec_nxt.cmd = SDC_NOP;
            default: dec_nxt.illegal = 1'b1;
         endcase
         if (pwr_r != SDC_ST_ACTIVE) begin
            dec_nxt.cmd = SDC_NONE;
            dec_nxt.illegal = 1'b1;
         end
      end
   end

   // registered decode, one per edge
   always_ff @(posedge clock) begin
      if (rst) begin
         dec_r <= '{cmd: SDC_NONE, bank: BA_RESET, addr: ADDR_RESET, auto_pre: 1'b0, illegal: 1'b0};
      end else begin
         dec_r <= dec_nxt;
      end
   end

   // power state
   always_ff @(posedge clock) begin
      if (rst) begin
         pwr_r <= SDC_ST_ACTIVE;
      end else begin
         case (pwr_nxt)
            SDC_ST_ACTIVE: pwr_r <= SDC_ST_ACTIVE;
            SDC_ST_PDOWN: pwr_r <= SDC_ST_PDOWN;
            SDC_ST_SREF: pwr_r <= SDC_ST_SREF;
            default: pwr_r <= SDC_ST_ACTIVE;
         endcase
      end
   end

   // internal refresh engine run level
   always_ff @(posedge clock) begin
      if (rst) begin
         refresh_r <= 1'b0;
      end else begin
         refresh_r <= (pwr_nxt == SDC_ST_SREF);
      end
   end

   // termination enable
   always_ff @(posedge clock) begin
      if (rst) begin
         odt_r <= 1'b0;
      end else begin
         odt_r <= odt_req && (pwr_nxt != SDC_ST_SREF);
      end
   end

   assign dec = dec_r;
   assign pwr_state = pwr_r;
   assign refresh_run = refresh_r;
   assign odt_en = odt_r;
endmodule : sdc_decoder

//--- tb/sdc_ctl.sv
// controller model driving the command pins
`timescale 1ns/1ns
module sdc_ctl (
   // clock and command pins
   input wire logic clock,
   output logic cke = 1'b1,
   output sdc_pkg::sdc_pins_t pins = 4'hf,
   output logic [2:0] bank_addr = 3'h0,
   output logic [13:0] addr = 14'h0000,
   output logic odt_req = 1'b0
);
   import sdc_pkg::*;
   // decoder keeps no bank state, so idle banks for refresh and mode load are assumed here
   task automatic issue(logic k, logic [3:0] c, logic [2:0] b, logic [13:0] a, logic o);
      @(negedge clock);
      {cke, pins, bank_addr, addr, odt_req} = {k, c, b, a, o};
   endtask : issue
endmodule : sdc_ctl

//--- tb/sdc_decoder_assertions.sv
// assertion checker for the command decoder
`timescale 1ns/1ns
module sdc_decoder_assertions #(
   parameter int DENSITY_MBIT = 256,
   parameter int COL_BITS = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // command pins
   input wire logic cke,
   input wire sdc_pkg::sdc_pins_t pins,
   input wire logic [sdc_pkg::BA_W-1:0] bank_addr,
   input wire logic [sdc_pkg::ROW_W-1:0] addr,
   input wire logic odt_req,
   // decoded outputs
   input wire sdc_pkg::sdc_dec_t dec,
   input wire logic refresh_run,
   input wire logic odt_en,
   input wire sdc_pkg::sdc_pwr_t pwr_state
);
   import sdc_pkg::*;
   logic ck_prev_r;
   logic [ROW_W-1:0] addr_r;
   logic [BA_W-1:0] ba_r;
   always_ff @(posedge clock) begin
      ck_prev_r <= rst ? 1'b0 : cke;
      addr_r <= addr;
      ba_r <= bank_addr;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_live;
      ck_prev_r && cke && pwr_state == SDC_ST_ACTIVE;
   endsequence
   sequence s_sr_go;
      ck_prev_r && !cke && pins == 4'h1 && pwr_state == SDC_ST_ACTIVE;
   endsequence
   property p_dec(logic [3:0] c, sdc_cmd_t e);
      s_live ##0 pins == c |=> dec.cmd == e;
   endproperty
   a_refresh_cmd: assert property (p_dec(4'h1, SDC_REFRESH)) else $error("bad refresh");
   a_write_cmd: assert property (p_dec(4'h4, SDC_WRITE)) else $error("bad write");
   a_mode_bank: assert property (s_live ##0 pins == 4'h0 |=> dec.cmd == SDC_MODE_LOAD
      && dec.bank == {DENSITY_MBIT >= 1024 ? ba_r[2] : 1'b0, ba_r[1:0]}) else $error("bad mode load");
   a_read_col: assert property (s_live ##0 pins == 4'h5 |=> dec.cmd == SDC_READ
      && dec.auto_pre == addr_r[AP_BIT] && dec.addr == (addr_r & ((14'h1 << COL_BITS) - 14'h1)))
      else $error("bad read");
   a_bad_code: assert property (s_live ##0 pins == 4'h6 |=> dec.illegal && dec.cmd == SDC_NONE)
      else $error("bad illegal");
   a_sref_entry: assert property (s_sr_go |=> dec.cmd == SDC_SR_ENTRY && refresh_run)
      else $error("bad sref entry");
   a_sref_exit: assert property (!ck_prev_r && cke && pins.cs_n && pwr_state == SDC_ST_SREF
      |=> dec.cmd == SDC_SR_EXIT && pwr_state == SDC_ST_ACTIVE) else $error("bad sref exit");
   a_sref_odt: assert property (pwr_state == SDC_ST_SREF |-> !odt_en) else $error("odt in sref");
endmodule : sdc_decoder_assertions
bind sdc_decoder sdc_decoder_assertions #(.DENSITY_MBIT(DENSITY_MBIT), .COL_BITS(COL_BITS))
   u_sdc_decoder_assertions (.clock(clock), .rst(rst), .cke(cke), .pins(pins), .bank_addr(bank_addr),
   .addr(addr), .odt_req(odt_req), .dec(dec), .refresh_run(refresh_run), .odt_en(odt_en), .pwr_state(pwr_state));

//--- tb/sdc_decoder_bench.sv
// self-checking bench for the command decoder
`timescale 1ns/1ns
module sdc_decoder_bench;
   import sdc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cke, odt_req, refresh_run, odt_en;
   sdc_pins_t pins;
   logic [2:0] bank_addr;
   logic [13:0] addr;
   sdc_dec_t dec;
   sdc_pwr_t pwr_state;
   int err_count = 0;
   int n_tests = 0;
   int seed = 34;
   sdc_cmd_t tbl[8] = '{SDC_MODE_LOAD, SDC_REFRESH, SDC_PRE_BANK, SDC_ACTIVATE, SDC_WRITE, SDC_READ,
      SDC_NONE, SDC_NOP};
   always #2 clock = ~clock;
   sdc_ctl u_sdc_ctl (.clock(clock), .cke(cke), .pins(pins), .bank_addr(bank_addr), .addr(addr),
      .odt_req(odt_req));
   sdc_decoder #(.DENSITY_MBIT(256), .COL_BITS(10)) u_sdc_decoder (.clock(clock), .rst(rst), .cke(cke),
      .pins(pins), .bank_addr(bank_addr), .addr(addr), .odt_req(odt_req), .dec(dec),
      .refresh_run(refresh_run), .odt_en(odt_en), .pwr_state(pwr_state));
   function automatic sdc_cmd_t exp_cmd(logic [3:0] c, logic a10);
      return c[3] ? SDC_DESELECT : (c == 4'h2 && a10) ? SDC_PRE_ALL : tbl[c[2:0]];
   endfunction : exp_cmd
   task automatic chk(string n, logic [13:0] e, logic [13:0] s);
      n_tests++;
      if (e !== s) begin
         err_count++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic step(logic t, logic k, logic [3:0] c, sdc_cmd_t ec, sdc_pwr_t ep);
      logic [13:0] a;
      logic [2:0] b;
      logic o;
      a = 14'($random(seed));
      b = 3'($random(seed));
      o = 1'($random(seed));
      if (!t) ec = exp_cmd(c, a[10]);
      u_sdc_ctl.issue(k, c, b, a, o);
      @(posedge clock);
      #1;
      chk("cmd", ec, dec.cmd);
      chk("illegal", 14'(ec == SDC_NONE && k), 14'(dec.illegal));
      chk("power", 14'(ep), 14'(pwr_state));
      chk("sref", 14'(ep == SDC_ST_SREF), 14'(refresh_run));
      chk("odt", 14'(o && ep != SDC_ST_SREF), 14'(odt_en));
      if (ec inside {SDC_MODE_LOAD, SDC_ACTIVATE}) chk("opcode", a, dec.addr);
      if (ec inside {SDC_READ, SDC_WRITE}) begin
         chk("col", a & 14'h03ff, dec.addr);
         chk("auto", 14'(a[10]), 14'(dec.auto_pre));
      end
      if (ec inside {SDC_MODE_LOAD, SDC_ACTIVATE, SDC_READ, SDC_WRITE, SDC_PRE_BANK})
         chk("bank", {11'h000, 1'b0, b[1:0]}, 14'(dec.bank));
   endtask : step
   task summarize;
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      @(posedge clock);
      repeat (80) step(1'b0, 1'b1, 4'($random(seed)), SDC_NONE, SDC_ST_ACTIVE);
      step(1'b1, 1'b0, 4'h1, SDC_SR_ENTRY, SDC_ST_SREF);
      step(1'b1, 1'b0, 4'hf, SDC_NONE, SDC_ST_SREF);
      step(1'b1, 1'b1, 4'hf, SDC_SR_EXIT, SDC_ST_ACTIVE);
      step(1'b1, 1'b0, 4'h7, SDC_PD_ENTRY, SDC_ST_PDOWN);
      step(1'b1, 1'b0, 4'hb, SDC_NONE, SDC_ST_PDOWN);
      step(1'b1, 1'b1, 4'h7, SDC_PD_EXIT, SDC_ST_ACTIVE);
      step(1'b1, 1'b1, 4'h6, SDC_NONE, SDC_ST_ACTIVE);
      summarize();
   end
   initial begin
      repeat (2000) @(posedge clock);
      err_count++;
      summarize();
   end
endmodule : sdc_decoder_bench
